//--- fsp_pkg.sv
// Constants and types for the flash status and protection register block.
// Assumes a 10 MHz system clock; serial link pins sampled on that clock.
package fsp_pkg;

	// ----------------------------------------
	// Clock and internal operation times
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int WRSR_TIME_NS = 5000;
	localparam int PROG_TIME_NS = 20000;
	localparam int ERASE_TIME_NS = 50000;
	localparam int WRSR_CYCLES = (WRSR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 10;

	// ----------------------------------------
	// Instruction codes
	// ----------------------------------------
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_RD_LOW = 8'h05;
	localparam logic [7:0] CMD_RD_HIGH = 8'h35;
	localparam logic [7:0] CMD_WRSR = 8'h01;
	localparam logic [7:0] CMD_PROG = 8'h02;
	localparam logic [7:0] CMD_SECT_ERASE = 8'h20;
	localparam logic [7:0] CMD_BLK_ERASE = 8'hD8;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'hC7;
	localparam logic [7:0] CMD_SUSPEND = 8'h75;
	localparam logic [7:0] CMD_RESUME = 8'h7A;

	// ----------------------------------------
	// Array geometry
	// ----------------------------------------
	localparam logic [23:0] ARRAY_TOP = 24'h1FFFFF;
	localparam logic [23:0] SECTOR_MASK = 24'h000FFF;
	localparam logic [23:0] BLOCK_MASK = 24'h00FFFF;
	localparam logic [23:0] BLOCK_BYTES = 24'h010000;
	localparam logic [23:0] SECTOR_BYTES = 24'h001000;
	localparam logic [23:0] HALF_BLOCK_BYTES = 24'h008000;
	localparam logic [23:0] ARRAY_BYTES = 24'h200000;

	// ----------------------------------------
	// Register field positions
	// ----------------------------------------
	localparam int LOW_BUSY = 0;
	localparam int LOW_WEL = 1;
	localparam int LOW_RANGE_LSB = 2;
	localparam int LOW_TB = 5;
	localparam int LOW_GRAN = 6;
	localparam int LOW_LM0 = 7;
	localparam int HIGH_LM1 = 0;
	localparam int HIGH_QE = 1;
	localparam int HIGH_RSVD = 2;
	localparam int HIGH_LOCK_LSB = 3;
	localparam int HIGH_INV = 6;
	localparam int HIGH_SUS = 7;

	typedef enum logic [1:0] {OP_NONE, OP_WRSR, OP_PROG, OP_ERASE} fsp_op_e;

	typedef struct packed {
		logic lm0;
		logic gran;
		logic tb;
		logic [2:0] range;
		logic inv;
		logic [2:0] lock;
		logic qe;
		logic lm1;
	} fsp_nv_s;

	typedef struct packed {
		logic [2:0] sclk;
		logic [2:0] cs_n;
		logic [1:0] si;
		logic [1:0] wp_n;
		logic [2:0] pwr;
	} fsp_sync_s;

	typedef struct packed {
		fsp_sync_s sy;
		fsp_nv_s nv;
		logic busy;
		logic write_enable_latch;
		logic paused_flag;
		fsp_op_e op;
		logic [CNT_W-1:0] cnt;
		logic [2:0] bitcnt;
		logic [2:0] nbytes;
		logic [7:0] shreg;
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [7:0] byte1;
		logic [7:0] byte2;
		logic so;
		logic so_oe_n;
		logic start;
		fsp_op_e start_op;
		logic [23:0] start_addr;
		logic chip;
	} fsp_state_s;

endpackage

//--- fsp_status_regs.sv
// Status/protection registers of a serial flash with a small serial front end.
// Assumes SCLK, CS, SI, WP and the power-cycle pin come from another domain.
//
// Functional notes
// - Busy flag high during program, erase or status write, else low.
// - Write-enable latch shown in low bit 1; gates status writes, program, erase.
// - Protect-range bits non-volatile, status-write only, bar program and erases.
// - Protect-range bits accepted only when hardware protection is not active.
// - Range code zero with invert-protect clear leaves whole array unprotected.
// - Granularity bit: 64KB blocks when clear, 4KB sectors when set.
// - Top/bottom bit: protect from top when clear, from bottom when set.
// - Invert-protect bit complements the protection map.
// - Lock mode 1 selects meaning of lock mode 0: pin guard or lock-down.
// - Lock modes other than 10, quad enable, invert-protect survive power cycles.
// - Quad enable disables the protect pin function.
// - Three one-time lock bits, set individually, never cleared.
// - Suspend sets paused flag; resume or power cycle clears it.
// - Lock modes: 00 soft, 01 pin, 10 until power cycle, 11 permanent.
`timescale 1ns/1ps
module fsp_status_regs (
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	input wire logic SCLK_IN,
	input wire logic CS_N_IN,
	input wire logic SI_IN,
	input wire logic WP_N_IN,
	input wire logic POWER_CYCLE_IN,
	output logic SO_OUT,
	output logic SO_OE_N_OUT,
	output logic [7:0] STATUS_LOW_OUT,
	output logic [7:0] STATUS_HIGH_OUT,
	output logic QUAD_MODE_OUT,
	output logic [2:0] SECURITY_LOCK_OUT,
	output logic ARRAY_START_OUT,
	output logic [1:0] ARRAY_OP_OUT,
	output logic [23:0] ARRAY_ADDR_OUT,
	output logic ARRAY_CHIP_OUT
);

	fsp_pkg::fsp_state_s s_q;
	fsp_pkg::fsp_state_s s_d;

	// ----------------------------------------
	// Protection map
	// ----------------------------------------
	function automatic logic is_protected(input logic [23:0] a,
		input fsp_pkg::fsp_nv_s nv);
		logic [23:0] size;
		logic hit;
		size = '0;
		hit = 1'b0;
		if (!nv.gran) begin
			size = fsp_pkg::BLOCK_BYTES << (nv.range - 3'h1);
		end else if (!nv.range[2]) begin
			size = fsp_pkg::SECTOR_BYTES << (nv.range - 3'h1);
		end else begin
			size = fsp_pkg::HALF_BLOCK_BYTES;
		end
		if (nv.tb) begin
			hit = a < size;
		end else begin
			hit = a >= (fsp_pkg::ARRAY_BYTES - size);
		end
		if (nv.range == 3'h0) begin
			hit = 1'b0;
		end else if (nv.range[2:1] == 2'h3) begin
			hit = 1'b1;
		end
		return hit ^ nv.inv;
	endfunction

	function automatic logic sr_locked(input fsp_pkg::fsp_nv_s nv,
		input logic wp_n);
		// pin guard off in quad mode
		return nv.lm1 | (nv.lm0 & ~nv.qe & ~wp_n);
	endfunction

	logic [7:0] low_v;
	logic [7:0] high_v;
	logic [23:0] first_a;
	logic [23:0] last_a;
	logic rise;
	logic fall;
	logic cs_rise;
	logic is_read;

	always_comb begin
		low_v = {s_q.nv.lm0, s_q.nv.gran, s_q.nv.tb, s_q.nv.range,
			s_q.write_enable_latch, s_q.busy};
		high_v = {s_q.paused_flag, s_q.nv.inv, s_q.nv.lock, 1'b0, s_q.nv.qe,
			s_q.nv.lm1};
		rise = s_q.sy.sclk[1] & ~s_q.sy.sclk[2];
		fall = ~s_q.sy.sclk[1] & s_q.sy.sclk[2];
		cs_rise = s_q.sy.cs_n[1] & ~s_q.sy.cs_n[2];
		is_read = (s_q.opcode == fsp_pkg::CMD_RD_LOW) |
			(s_q.opcode == fsp_pkg::CMD_RD_HIGH);
		first_a = s_q.addr;
		last_a = s_q.addr;
		if (s_q.opcode == fsp_pkg::CMD_SECT_ERASE) begin
			first_a = s_q.addr & ~fsp_pkg::SECTOR_MASK;
			last_a = s_q.addr | fsp_pkg::SECTOR_MASK;
		end else if (s_q.opcode == fsp_pkg::CMD_BLK_ERASE) begin
			first_a = s_q.addr & ~fsp_pkg::BLOCK_MASK;
			last_a = s_q.addr | fsp_pkg::BLOCK_MASK;
		end else if (s_q.opcode == fsp_pkg::CMD_CHIP_ERASE) begin
			first_a = '0;
			last_a = fsp_pkg::ARRAY_TOP;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.start = 1'b0;
		s_d.sy.sclk = {s_q.sy.sclk[1:0], SCLK_IN};
		s_d.sy.cs_n = {s_q.sy.cs_n[1:0], CS_N_IN};
		s_d.sy.si = {s_q.sy.si[0], SI_IN};
		s_d.sy.wp_n = {s_q.sy.wp_n[0], WP_N_IN};
		s_d.sy.pwr = {s_q.sy.pwr[1:0], POWER_CYCLE_IN};

		if (s_q.busy) begin
			s_d.cnt = s_q.cnt - 1'b1;
			if (s_q.cnt == 1) begin
				s_d.busy = 1'b0;
				s_d.op = fsp_pkg::OP_NONE;
			end
		end

		if (s_q.sy.cs_n[1]) begin
			s_d.bitcnt = '0;
			s_d.nbytes = '0;
			s_d.so_oe_n = 1'b1;
		end else begin
			if (rise) begin
				s_d.shreg = {s_q.shreg[6:0], s_q.sy.si[1]};
				s_d.bitcnt = s_q.bitcnt + 1'b1;
				if (s_q.bitcnt == 3'h7) begin
					if (s_q.nbytes != 3'h7) begin
						s_d.nbytes = s_q.nbytes + 1'b1;
					end
					case (s_q.nbytes)
						3'h0: s_d.opcode = s_d.shreg;
						3'h1: begin
							s_d.byte1 = s_d.shreg;
							s_d.addr[23:16] = s_d.shreg;
						end
						3'h2: begin
							s_d.byte2 = s_d.shreg;
							s_d.addr[15:8] = s_d.shreg;
						end
						3'h3: s_d.addr[7:0] = s_d.shreg;
						default: ;
					endcase
				end
			end
			if (fall && is_read && s_q.nbytes != 3'h0) begin
				s_d.so_oe_n = 1'b0;
				if (s_q.opcode == fsp_pkg::CMD_RD_LOW) begin
					s_d.so = low_v[~s_q.bitcnt];
				end else begin
					s_d.so = high_v[~s_q.bitcnt];
				end
			end
		end

		// Instructions execute when chip select rises on a byte boundary
		if (cs_rise && s_q.bitcnt == 3'h0) begin
			case (s_q.opcode)
				fsp_pkg::CMD_WREN: begin
					if (s_q.nbytes == 3'h1 && !s_q.busy) begin
						s_d.write_enable_latch = 1'b1;
					end
				end
				fsp_pkg::CMD_WRDI: begin
					if (s_q.nbytes == 3'h1 && !s_q.busy) begin
						s_d.write_enable_latch = 1'b0;
					end
				end
				fsp_pkg::CMD_WRSR: begin
					if ((s_q.nbytes == 3'h2 || s_q.nbytes == 3'h3) && s_q.write_enable_latch &&
						!s_q.busy && !sr_locked(s_q.nv, s_q.sy.wp_n[1])) begin
						s_d.nv.lm0 = s_q.byte1[fsp_pkg::LOW_LM0];
						s_d.nv.gran = s_q.byte1[fsp_pkg::LOW_GRAN];
						s_d.nv.tb = s_q.byte1[fsp_pkg::LOW_TB];
						s_d.nv.range = s_q.byte1[fsp_pkg::LOW_RANGE_LSB +: 3];
						if (s_q.nbytes == 3'h3) begin
							s_d.nv.inv = s_q.byte2[fsp_pkg::HIGH_INV];
							s_d.nv.lock = s_q.nv.lock |
								s_q.byte2[fsp_pkg::HIGH_LOCK_LSB +: 3];
							s_d.nv.qe = s_q.byte2[fsp_pkg::HIGH_QE];
							s_d.nv.lm1 = s_q.byte2[fsp_pkg::HIGH_LM1];
						end
						s_d.write_enable_latch = 1'b0;
						s_d.busy = 1'b1;
						s_d.op = fsp_pkg::OP_WRSR;
						s_d.cnt = fsp_pkg::CNT_W'(fsp_pkg::WRSR_CYCLES);
					end
				end
				fsp_pkg::CMD_PROG, fsp_pkg::CMD_SECT_ERASE,
				fsp_pkg::CMD_BLK_ERASE, fsp_pkg::CMD_CHIP_ERASE: begin
					if (s_q.write_enable_latch && !s_q.busy && !s_q.paused_flag &&
						!is_protected(first_a, s_q.nv) &&
						!is_protected(last_a, s_q.nv) &&
						((s_q.opcode == fsp_pkg::CMD_PROG && s_q.nbytes >= 3'h5) ||
						(s_q.opcode == fsp_pkg::CMD_CHIP_ERASE &&
						s_q.nbytes == 3'h1) || s_q.nbytes == 3'h4)) begin
						s_d.write_enable_latch = 1'b0;
						s_d.busy = 1'b1;
						s_d.start = 1'b1;
						s_d.start_addr = s_q.addr;
						s_d.chip = s_q.opcode == fsp_pkg::CMD_CHIP_ERASE;
						if (s_q.opcode == fsp_pkg::CMD_PROG) begin
							s_d.op = fsp_pkg::OP_PROG;
							s_d.cnt = fsp_pkg::CNT_W'(fsp_pkg::PROG_CYCLES);
						end else begin
							s_d.op = fsp_pkg::OP_ERASE;
							s_d.cnt = fsp_pkg::CNT_W'(fsp_pkg::ERASE_CYCLES);
						end
						s_d.start_op = s_d.op;
					end
				end
				fsp_pkg::CMD_SUSPEND: begin
					if (s_q.nbytes == 3'h1 && s_q.busy &&
						s_q.op != fsp_pkg::OP_WRSR) begin
						s_d.paused_flag = 1'b1;
						s_d.busy = 1'b0;
						s_d.cnt = s_q.cnt;
					end
				end
				fsp_pkg::CMD_RESUME: begin
					if (s_q.nbytes == 3'h1 && s_q.paused_flag) begin
						s_d.paused_flag = 1'b0;
						s_d.busy = 1'b1;
					end
				end
				default: ;
			endcase
		end

		if (s_q.sy.pwr[1] && !s_q.sy.pwr[2]) begin
			s_d.busy = 1'b0;
			s_d.write_enable_latch = 1'b0;
			s_d.paused_flag = 1'b0;
			s_d.op = fsp_pkg::OP_NONE;
			s_d.cnt = '0;
			if (s_q.nv.lm1 && !s_q.nv.lm0) begin
				s_d.nv.lm1 = 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			s_q <= '0;
			s_q.sy.cs_n <= 3'h7;
			s_q.so_oe_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign SO_OUT = s_q.so;
	assign SO_OE_N_OUT = s_q.so_oe_n;
	assign STATUS_LOW_OUT = low_v;
	assign STATUS_HIGH_OUT = high_v;
	assign QUAD_MODE_OUT = s_q.nv.qe;
	assign SECURITY_LOCK_OUT = s_q.nv.lock;
	assign ARRAY_START_OUT = s_q.start;
	assign ARRAY_OP_OUT = s_q.start_op;
	assign ARRAY_ADDR_OUT = s_q.start_addr;
	assign ARRAY_CHIP_OUT = s_q.chip;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);

	sequence s_wrsr_try;
		cs_rise && s_q.bitcnt == 3'h0 && s_q.opcode == fsp_pkg::CMD_WRSR;
	endsequence

	sequence s_busy_rise;
		!s_q.busy ##1 s_q.busy && !$past(s_q.paused_flag);
	endsequence

	a_wel_gate: assert property (s_q.start |-> $past(s_q.write_enable_latch))
		else $error("array start without write enable");
	a_busy_start: assert property (s_q.start |-> s_q.busy)
		else $error("array start without busy");
	a_busy_len: assert property (s_busy_rise |->
		s_q.busy [*8] ##[1:500] !s_q.busy)
		else $error("busy time wrong");
	a_prot_bar: assert property (s_q.start && !s_q.chip |->
		!is_protected(s_q.start_addr, s_q.nv))
		else $error("protected area written");
	a_hw_lock: assert property (s_wrsr_try and
		sr_locked(s_q.nv, s_q.sy.wp_n[1]) |=> $stable(s_q.nv))
		else $error("locked status register changed");
	a_lock_sticky: assert property ((s_q.nv.lock & ~s_d.nv.lock) == 3'h0)
		else $error("one-time lock cleared");
	a_rsvd_zero: assert property (STATUS_HIGH_OUT[fsp_pkg::HIGH_RSVD] == 1'b0)
		else $error("reserved bit set");
	a_sus_idle: assert property (s_q.paused_flag |-> !s_q.busy && !s_q.start)
		else $error("busy while paused");

endmodule

//--- fsp_host_model.sv
// Serial host model: mode-0 frames, eight system clocks per serial bit.
// Assumes the bench calls send() and watches rd_stb_out for read bytes.
`timescale 1ns/1ps
module fsp_host_model (
	input wire logic clk_in,
	input wire logic so_in,
	output logic sclk_out,
	output logic cs_n_out,
	output logic si_out,
	output logic [7:0] rd_byte_out,
	output logic rd_stb_out
);
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
		rd_byte_out = 8'h00;
		rd_stb_out = 1'b0;
	end

	// ------------------------------
	// Frame transfer
	// ------------------------------
	task automatic send(input int n, input logic [39:0] d, input logic rd);
		int i;
		@(posedge clk_in) #1;
		cs_n_out = 1'b0;
		for (i = 0; i < n * 8; i++) begin
			si_out = d[39 - i];
			repeat (4) @(posedge clk_in);
			#1 rd_byte_out = {rd_byte_out[6:0], so_in};
			sclk_out = 1'b1;
			repeat (4) @(posedge clk_in);
			#1 sclk_out = 1'b0;
		end
		repeat (4) @(posedge clk_in);
		#1 cs_n_out = 1'b1;
		// Released line shows no stale bit
		si_out = ~si_out;
		rd_stb_out = rd;
		@(posedge clk_in) #1 rd_stb_out = 1'b0;
		repeat (6) @(posedge clk_in);
	endtask
endmodule

//--- fsp_status_regs_bench.sv
// Bench for the status/protection registers, reached over the serial pins.
// Assumes the host model paces frames from the 10 MHz system clock.
`timescale 1ns/1ps
module fsp_status_regs_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wp_n = 1'b1;
	logic pwr = 1'b0;
	logic sclk, cs_n, si, so, so_oe_n, quad, a_start, a_chip, rd_stb;
	logic [7:0] st_low, st_high, rd_byte;
	logic [2:0] sec_lock;
	logic [1:0] a_op;
	logic [23:0] a_addr;
	logic [7:0] exp_rd[$];
	logic [26:0] exp_arr[$];
	int fails = 0;
	int n_tests = 0;

	always #50 clk = ~clk;

	fsp_status_regs fsp_status_regs_inst (
		.CLK_IN(clk), .RESET_IN(rst), .SCLK_IN(sclk), .CS_N_IN(cs_n),
		.SI_IN(si), .WP_N_IN(wp_n), .POWER_CYCLE_IN(pwr), .SO_OUT(so),
		.SO_OE_N_OUT(so_oe_n), .STATUS_LOW_OUT(st_low),
		.STATUS_HIGH_OUT(st_high), .QUAD_MODE_OUT(quad),
		.SECURITY_LOCK_OUT(sec_lock), .ARRAY_START_OUT(a_start),
		.ARRAY_OP_OUT(a_op), .ARRAY_ADDR_OUT(a_addr),
		.ARRAY_CHIP_OUT(a_chip)
	);

	fsp_host_model fsp_host_model_inst (
		.clk_in(clk), .so_in(so), .sclk_out(sclk), .cs_n_out(cs_n),
		.si_out(si), .rd_byte_out(rd_byte), .rd_stb_out(rd_stb)
	);

	// ------------------------------
	// Checking and closing
	// ------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		if (fails == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Results taken off the queues as they appear
	always @(negedge clk) begin
		if (rd_stb === 1'b1) begin
			chk(32'(rd_byte), 32'(exp_rd.pop_front()));
		end
		if (a_start === 1'b1) begin
			chk({5'h00, a_chip, a_op, a_addr}, exp_arr.size() > 0 ?
				32'(exp_arr.pop_front()) : 32'hFFFFFFFF);
		end
	end

	// ------------------------------
	// Serial operations
	// ------------------------------
	task automatic rd(input logic [7:0] code, input logic [7:0] e);
		exp_rd.push_back(e);
		fsp_host_model_inst.send(2, {code, 32'h0}, 1'b1);
	endtask

	task automatic wait_idle(output int n);
		n = 0;
		while (st_low[0] !== 1'b0) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 1000) begin
				fails++;
				close_out();
			end
		end
	endtask

	task automatic cmd(input logic [7:0] code);
		fsp_host_model_inst.send(1, {code, 32'h0}, 1'b0);
	endtask

	task automatic wr_chk(input logic [7:0] l, h, el, eh);
		int n;
		cmd(8'h06);
		fsp_host_model_inst.send(3, {8'h01, l, h, 16'h0}, 1'b0);
		wait_idle(n);
		cmd(8'h04);
		rd(8'h05, el);
		rd(8'h35, eh);
	endtask

	task automatic op(input logic [7:0] code, input logic [23:0] a,
		input int nb, input logic ok, input logic [1:0] o);
		cmd(8'h06);
		if (ok) begin
			exp_arr.push_back({code == 8'hC7, o, a});
		end
		fsp_host_model_inst.send(nb, {code, a, 8'hA5}, 1'b0);
	endtask

	task automatic pulse_pwr();
		@(posedge clk) #1 pwr = 1'b1;
		repeat (5) @(posedge clk);
		#1 pwr = 1'b0;
		repeat (5) @(posedge clk);
	endtask

	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		int n;
		logic [23:0] a;
		void'($urandom(23));
		a = 24'($urandom() & 32'h1FFFF);
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge clk);
		rd(8'h05, 8'h00);
		rd(8'h35, 8'h00);
		fsp_host_model_inst.send(3, {8'h01, 16'hFFFF, 16'h0}, 1'b0);
		rd(8'h05, 8'h00);
		cmd(8'h06);
		rd(8'h05, 8'h02);
		wr_chk(8'h2B, 8'h4E, 8'h28, 8'h4A);
		chk(32'({quad, sec_lock}), 32'h9);
		op(8'h02, a, 5, 1'b1, 2'h2);
		wait_idle(n);
		chk(32'(n inside {[185:200]}), 32'h1);
		op(8'h02, a | 24'h100000, 5, 1'b0, 2'h2);
		wait_idle(n);
		chk(32'(n), 32'h0);
		wr_chk(8'h00, 8'h00, 8'h00, 8'h08);
		op(8'h02, 24'h100000, 5, 1'b1, 2'h2);
		cmd(8'h75);
		chk(32'({st_high[7], st_low[0]}), 32'h2);
		cmd(8'h7A);
		chk(32'({st_high[7], st_low[0]}), 32'h1);
		wait_idle(n);
		wr_chk(8'h44, 8'h00, 8'h44, 8'h08);
		op(8'h20, 24'h1FE000, 4, 1'b1, 2'h3);
		wait_idle(n);
		op(8'h20, 24'h1FF000, 4, 1'b0, 2'h3);
		wait_idle(n);
		op(8'hD8, 24'h000000, 4, 1'b1, 2'h3);
		wait_idle(n);
		op(8'hC7, 24'h000000, 1, 1'b0, 2'h3);
		wait_idle(n);
		wr_chk(8'h80, 8'h00, 8'h80, 8'h08);
		@(posedge clk) #1 wp_n = 1'b0;
		wr_chk(8'h00, 8'h00, 8'h80, 8'h08);
		@(posedge clk) #1 wp_n = 1'b1;
		wr_chk(8'h00, 8'h01, 8'h00, 8'h09);
		wr_chk(8'h80, 8'h00, 8'h00, 8'h09);
		op(8'h02, 24'h000100, 5, 1'b1, 2'h2);
		cmd(8'h75);
		pulse_pwr();
		rd(8'h35, 8'h08);
		rd(8'h05, 8'h00);
		// Pin driven low, not tied, after quad mode is set
		wr_chk(8'h80, 8'h02, 8'h80, 8'h0A);
		@(posedge clk) #1 wp_n = 1'b0;
		wr_chk(8'h00, 8'h02, 8'h00, 8'h0A);
		chk(32'(exp_arr.size() + exp_rd.size()), 32'h0);
		close_out();
	end
endmodule
